// *** rtcc_cfg.svh ***
// Offsets, field positions, reset values and timing counts of the clock control block.
`ifndef RTCC_CFG_SVH
`define RTCC_CFG_SVH

// ------------------------------------------------------------
// Register indices within the first bank
// ------------------------------------------------------------
`define RTCC_IDX_W            7
`define RTCC_IDX_RATE         7'h0A
`define RTCC_IDX_MODE         7'h0B
`define RTCC_IDX_FLAGS        7'h0C
`define RTCC_IDX_POWER        7'h0D

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define RTCC_RATE_UIP_BIT     7
`define RTCC_RATE_DIV_HI      6
`define RTCC_RATE_DIV_LO      4
`define RTCC_RATE_SEL_HI      3
`define RTCC_RATE_SEL_LO      0
`define RTCC_MODE_SET_BIT     7
`define RTCC_MODE_PIE_BIT     6
`define RTCC_MODE_AIE_BIT     5
`define RTCC_MODE_UIE_BIT     4
`define RTCC_MODE_BIN_BIT     2
`define RTCC_MODE_H24_BIT     1
`define RTCC_MODE_DST_BIT     0
`define RTCC_FLAG_IRQ_BIT     7
`define RTCC_FLAG_PER_BIT     6
`define RTCC_FLAG_ALM_BIT     5
`define RTCC_FLAG_UPD_BIT     4
`define RTCC_POWER_OK_BIT     7

// ------------------------------------------------------------
// Writable masks and reset values
// ------------------------------------------------------------
`define RTCC_RATE_WMASK       8'h7F
`define RTCC_MODE_WMASK       8'hF7
`define RTCC_RATE_RESET       7'h20
`define RTCC_MODE_RESET       8'h00
`define RTCC_RD_NONE          8'h00

// ------------------------------------------------------------
// Divider codes and periodic rate codes
// ------------------------------------------------------------
`define RTCC_DIV_NORMAL       3'b010
`define RTCC_RATE_NONE        4'h0
`define RTCC_RATE_ALIAS1      4'h1
`define RTCC_RATE_ALIAS2      4'h2
`define RTCC_RATE_ALIAS1_TO   4'h8
`define RTCC_RATE_ALIAS2_TO   4'h9

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define RTCC_TB_HZ            32768
`define RTCC_DIV_W            15
`define RTCC_UIP_TIME_US      2444
`define RTCC_UIP_TICKS        ((`RTCC_UIP_TIME_US * `RTCC_TB_HZ) / 1000000)

`endif

// *** rtcc_pkg.sv ***
// Types shared by the clock control block.
package rtcc_pkg;

   // ------------------------------------------------------------
   // Divider chain modes
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      RTCC_DIV_STOP  = 2'b00,
      RTCC_DIV_RUN   = 2'b01,
      RTCC_DIV_RESET = 2'b11
   } rtcc_div_e;

   typedef logic [7:0] rtcc_byte_t;

   // Values 00x stop the oscillator, 11x hold the chain in reset, the rest run.
   function automatic rtcc_div_e rtcc_div_decode(input logic [2:0] code);
      rtcc_div_e mode;
      mode = RTCC_DIV_RUN;
      case (code[2:1])
         2'b00:   mode = RTCC_DIV_STOP;
         2'b11:   mode = RTCC_DIV_RESET;
         default: mode = RTCC_DIV_RUN;
      endcase
      return mode;
   endfunction

endpackage

// *** rtcc_sync.sv ***
// Two-flop synchroniser for levels arriving from pins.
module rtcc_sync #(
   parameter int W = 1
) (
   input  wire logic         clock_in,
   input  wire logic         rst_n_in,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta_r;

   // The first stage feeds only the second stage.
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_r   <= '0;
         sync_out <= '0;
      end else begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end

endmodule // rtcc_sync

// *** rtcc_timebase.sv ***
// Divider chain, periodic event and update-in-progress window.
`include "rtcc_cfg.svh"
module rtcc_timebase
   import rtcc_pkg::*;
#(
   parameter int DIV_W     = `RTCC_DIV_W,
   parameter int UIP_TICKS = `RTCC_UIP_TICKS
) (
   input  wire logic       clock_in,
   input  wire logic       rst_n_in,
   input  wire logic       tick_in,
   input  wire logic [2:0] div_code_in,
   input  wire logic [3:0] rate_code_in,
   input  wire logic       inhibit_in,
   output logic            periodic_out,
   output logic            update_out,
   output logic            uip_out
);

   logic [DIV_W-1:0] chain_r;
   rtcc_div_e        mode;
   logic [3:0]       eff_rate;
   logic [DIV_W-1:0] per_mask;
   logic             step;
   logic             wrap;

   // Codes 1 and 2 alias to codes 8 and 9.
   function automatic logic [3:0] rtcc_eff_rate(input logic [3:0] code);
      logic [3:0] r;
      r = code;
      if (code == `RTCC_RATE_ALIAS1) begin
         r = `RTCC_RATE_ALIAS1_TO;
      end else if (code == `RTCC_RATE_ALIAS2) begin
         r = `RTCC_RATE_ALIAS2_TO;
      end
      return r;
   endfunction

   assign mode     = rtcc_div_decode(div_code_in);
   assign eff_rate = rtcc_eff_rate(rate_code_in);
   // Code n divides the time base by two to the power n-1.
   assign per_mask = DIV_W'((1 << (eff_rate - 4'h1)) - 1);
   assign step     = tick_in && (mode == RTCC_DIV_RUN);
   assign wrap     = step && (&chain_r);

   // ------------------------------------------------------------
   // Divider chain
   // ------------------------------------------------------------
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         chain_r <= '0;
      end else if (mode == RTCC_DIV_RESET) begin
         chain_r <= '0;
      end else if (step) begin
         chain_r <= chain_r + DIV_W'(1);
      end
   end

   // ------------------------------------------------------------
   // Events and window
   // ------------------------------------------------------------
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         periodic_out <= 1'b0;
         update_out   <= 1'b0;
         uip_out      <= 1'b0;
      end else begin
         periodic_out <= step && (eff_rate != `RTCC_RATE_NONE)
                         && ((chain_r & per_mask) == per_mask);
         update_out   <= wrap && !inhibit_in;
         // The window ends with the update itself, so it never reads stale.
         uip_out      <= (mode == RTCC_DIV_RUN) && !inhibit_in
                         && (chain_r >= DIV_W'((1 << DIV_W) - UIP_TICKS));
      end
   end

endmodule // rtcc_timebase

// *** rtcc_ctrl_status.sv ***
// Top of the clock control block: index/data port, control and status registers.
// ------------------------------------------------------------
// ------------------------------------------------------------
`include "rtcc_cfg.svh"
module rtcc_ctrl_status
   import rtcc_pkg::*;
#(
   parameter int UIP_TICKS = `RTCC_UIP_TICKS
) (
   input  wire logic       clock_in,
   input  wire logic       rst_n_in,
   input  wire logic       index_wr_in,
   input  wire logic       data_wr_in,
   input  wire logic       data_rd_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic       osc_32k_in,
   input  wire logic       power_ok_in,
   input  wire logic       alarm_match_in,
   output logic      [7:0] rdata_out,
   output logic            irq_out,
   output logic            update_tick_out,
   output logic            binary_fmt_out,
   output logic            hour24_out,
   output logic            dst_en_out
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [`RTCC_IDX_W-1:0] index_r;
   logic [6:0]             rate_r;
   rtcc_byte_t             mode_r;
   logic                   per_flag_r;
   logic                   alm_flag_r;
   logic                   upd_flag_r;
   logic                   power_kept_r;
   logic                   osc_prev_r;
   logic [1:0]             pins_sync;
   logic                   osc_s;
   logic                   power_s;
   logic                   tick;
   logic                   periodic_ev;
   logic                   update_ev;
   logic                   uip;
   logic                   wr_rate;
   logic                   wr_mode;
   logic                   rd_flags;
   logic                   rd_power;
   logic                   per_flag_nxt;
   logic                   alm_flag_nxt;
   logic                   upd_flag_nxt;
   logic                   irq_nxt;
   rtcc_byte_t             rd_mux;

   function automatic logic rtcc_hit(input logic [`RTCC_IDX_W-1:0] idx,
                                     input logic [`RTCC_IDX_W-1:0] reg_idx,
                                     input logic                   strobe);
      return strobe && (idx == reg_idx);
   endfunction

   // ------------------------------------------------------------
   // Pin synchronisers and time base tick
   // ------------------------------------------------------------
   rtcc_sync #(
      .W (2)
   ) u_sync (
      .clock_in (clock_in),
      .rst_n_in (rst_n_in),
      .async_in ({!power_ok_in, osc_32k_in}),
      .sync_out (pins_sync)
   );

   // The power pin travels inverted, so the cleared synchroniser reads as power kept.
   // Otherwise every reset would record a false power loss before the pin arrives.
   assign osc_s   = pins_sync[0];
   assign power_s = !pins_sync[1];

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         osc_prev_r <= 1'b0;
      end else begin
         osc_prev_r <= osc_s;
      end
   end

   assign tick = osc_s && !osc_prev_r;

   rtcc_timebase #(
      .DIV_W     (`RTCC_DIV_W),
      .UIP_TICKS (UIP_TICKS)
   ) u_timebase (
      .clock_in     (clock_in),
      .rst_n_in     (rst_n_in),
      .tick_in      (tick),
      .div_code_in  (rate_r[`RTCC_RATE_DIV_HI:`RTCC_RATE_DIV_LO]),
      .rate_code_in (rate_r[`RTCC_RATE_SEL_HI:`RTCC_RATE_SEL_LO]),
      .inhibit_in   (mode_r[`RTCC_MODE_SET_BIT]),
      .periodic_out (periodic_ev),
      .update_out   (update_ev),
      .uip_out      (uip)
   );

   // ------------------------------------------------------------
   // Index and data port decode
   // ------------------------------------------------------------
   assign wr_rate  = rtcc_hit(index_r, `RTCC_IDX_RATE, data_wr_in);
   assign wr_mode  = rtcc_hit(index_r, `RTCC_IDX_MODE, data_wr_in);
   assign rd_flags = rtcc_hit(index_r, `RTCC_IDX_FLAGS, data_rd_in);
   assign rd_power = rtcc_hit(index_r, `RTCC_IDX_POWER, data_rd_in);

   // The host selects a byte through the index port before the data access.
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         index_r <= '0;
      end else if (index_wr_in) begin
         index_r <= wdata_in[`RTCC_IDX_W-1:0];
      end
   end

   // ------------------------------------------------------------
   // Rate and mode registers
   // ------------------------------------------------------------
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rate_r <= `RTCC_RATE_RESET;
      end else if (wr_rate) begin
         // Bit 7 is status only, so the write never reaches it.
         rate_r <= wdata_in[6:0];
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mode_r <= `RTCC_MODE_RESET;
      end else if (wr_mode) begin
         mode_r <= wdata_in & `RTCC_MODE_WMASK;
      end
   end

   // ------------------------------------------------------------
   // Interrupt flags
   // ------------------------------------------------------------
   // A new event in the same cycle as a flag read survives the clear,
   // so the host sees it on its next read instead of losing it.
   always_comb begin
      per_flag_nxt = (per_flag_r && !rd_flags) || periodic_ev;
      alm_flag_nxt = (alm_flag_r && !rd_flags) || alarm_match_in;
      upd_flag_nxt = (upd_flag_r && !rd_flags) || update_ev;
      irq_nxt      = (per_flag_nxt && mode_r[`RTCC_MODE_PIE_BIT])
                     || (alm_flag_nxt && mode_r[`RTCC_MODE_AIE_BIT])
                     || (upd_flag_nxt && mode_r[`RTCC_MODE_UIE_BIT]);
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         per_flag_r <= 1'b0;
         alm_flag_r <= 1'b0;
         upd_flag_r <= 1'b0;
         irq_out    <= 1'b0;
      end else begin
         per_flag_r <= per_flag_nxt;
         alm_flag_r <= alm_flag_nxt;
         upd_flag_r <= upd_flag_nxt;
         irq_out    <= irq_nxt;
      end
   end

   // ------------------------------------------------------------
   // Power status
   // ------------------------------------------------------------
   // Loss is sticky until the host reads the status byte with power good.
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         power_kept_r <= 1'b1;
      end else if (!power_s) begin
         power_kept_r <= 1'b0;
      end else if (rd_power) begin
         power_kept_r <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   always_comb begin
      rd_mux = `RTCC_RD_NONE;
      case (index_r)
         `RTCC_IDX_RATE: begin
            rd_mux = {uip, rate_r};
         end
         `RTCC_IDX_MODE: begin
            rd_mux = mode_r;
         end
         `RTCC_IDX_FLAGS: begin
            rd_mux = {irq_out, per_flag_r, alm_flag_r, upd_flag_r, 4'h0};
         end
         `RTCC_IDX_POWER: begin
            rd_mux = {power_kept_r, 7'h00};
         end
         default: begin
            rd_mux = `RTCC_RD_NONE;
         end
      endcase
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_out <= `RTCC_RD_NONE;
      end else if (data_rd_in) begin
         rdata_out <= rd_mux;
      end
   end

   // ------------------------------------------------------------
   // Outputs toward the time counters
   // ------------------------------------------------------------
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         update_tick_out <= 1'b0;
         binary_fmt_out  <= 1'b0;
         hour24_out      <= 1'b0;
         dst_en_out      <= 1'b0;
      end else begin
         update_tick_out <= update_ev;
         binary_fmt_out  <= mode_r[`RTCC_MODE_BIN_BIT];
         hour24_out      <= mode_r[`RTCC_MODE_H24_BIT];
         // The counters apply the April and October shifts when this is set.
         dst_en_out      <= mode_r[`RTCC_MODE_DST_BIT];
      end
   end

endmodule // rtcc_ctrl_status

// *** rtcc_ctrl_status_checker.sv ***
// Port assertions for the clock control block.
`include "rtcc_cfg.svh"
module rtcc_ctrl_status_checker #(
   parameter int UIP_TICKS = `RTCC_UIP_TICKS
) (
   input wire logic       clock_in,
   input wire logic       rst_n_in,
   input wire logic       index_wr_in,
   input wire logic       data_wr_in,
   input wire logic       data_rd_in,
   input wire logic [7:0] wdata_in,
   input wire logic       osc_32k_in,
   input wire logic       power_ok_in,
   input wire logic       alarm_match_in,
   input wire logic [7:0] rdata_out,
   input wire logic       irq_out,
   input wire logic       update_tick_out,
   input wire logic       binary_fmt_out,
   input wire logic       hour24_out,
   input wire logic       dst_en_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------
   // Shadow copies of index, rate and mode
   // ------------------------------
   logic [6:0] idx_r;
   logic [6:0] rate_r;
   logic [7:0] mode_r;
   always_ff @(posedge clock_in or negedge rst_n_in)
      if (!rst_n_in) idx_r <= 7'h00;
      else if (index_wr_in) idx_r <= wdata_in[6:0];
   always_ff @(posedge clock_in or negedge rst_n_in)
      if (!rst_n_in) rate_r <= 7'h20;
      else if (data_wr_in && idx_r == 7'h0A) rate_r <= wdata_in[6:0];
   always_ff @(posedge clock_in or negedge rst_n_in)
      if (!rst_n_in) mode_r <= 8'h00;
      else if (data_wr_in && idx_r == 7'h0B) mode_r <= wdata_in & 8'hF7;
   default clocking dc @(posedge clock_in);
   endclocking
   default disable iff (!rst_n_in);
   rate_read_a: assert property (
      data_rd_in && idx_r == 7'h0A |=> rdata_out[6:0] == $past(rate_r))
      else $error("rate read back wrong");
   uip_stopped_a: assert property (
      data_rd_in && idx_r == 7'h0A && rate_r[6:5] inside {2'b00, 2'b11} |=> !rdata_out[7])
      else $error("update flag set while divider not running");
   mode_read_a: assert property (
      data_rd_in && idx_r == 7'h0B |=> rdata_out == $past(mode_r))
      else $error("mode read back wrong");
   flag_read_a: assert property (
      data_rd_in && idx_r == 7'h0C |=> rdata_out[7] == $past(irq_out) && rdata_out[3:0] == 4'h0)
      else $error("flag read wrong");
   void_read_a: assert property (
      data_rd_in && (idx_r < 7'h0A || idx_r > 7'h0D) |=> rdata_out == 8'h00)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property (!data_rd_in |=> $stable(rdata_out))
      else $error("read data moved without a read");
   fmt_out_a: assert property (
      {binary_fmt_out, hour24_out, dst_en_out} == $past(mode_r[2:0]))
      else $error("format outputs do not follow mode");
   alarm_irq_a: assert property (alarm_match_in && mode_r[5] |=> irq_out)
      else $error("enabled alarm gave no interrupt");
   upd_pulse_a: assert property (update_tick_out |=> !update_tick_out)
      else $error("update pulse too long");
   // The update pulse trails the inhibit bit by two registers, so three inhibited cycles.
   upd_hold_a: assert property (
      mode_r[7] && $past(mode_r[7]) && $past(mode_r[7], 2) |-> !update_tick_out)
      else $error("update while inhibited");
endmodule // rtcc_ctrl_status_checker

bind rtcc_ctrl_status rtcc_ctrl_status_checker #(.UIP_TICKS(UIP_TICKS)) i_rtcc_ctrl_status_checker (
   .clock_in(clock_in), .rst_n_in(rst_n_in), .index_wr_in(index_wr_in),
   .data_wr_in(data_wr_in), .data_rd_in(data_rd_in), .wdata_in(wdata_in),
   .osc_32k_in(osc_32k_in), .power_ok_in(power_ok_in), .alarm_match_in(alarm_match_in),
   .rdata_out(rdata_out), .irq_out(irq_out), .update_tick_out(update_tick_out),
   .binary_fmt_out(binary_fmt_out), .hour24_out(hour24_out), .dst_en_out(dst_en_out));

// *** rtcc_host.sv ***
// Host processor model using the index and data ports.
module rtcc_host (
   input  wire logic       clock_in,
   input  wire logic [7:0] rdata_in,
   output logic            index_wr_out,
   output logic            data_wr_out,
   output logic            data_rd_out,
   output logic      [7:0] wdata_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------
   // Port cycles
   // ------------------------------
   initial begin
      index_wr_out = 1'b0;
      data_wr_out = 1'b0;
      data_rd_out = 1'b0;
      wdata_out = 8'h00;
   end
   // Index first, data access on the next edge.
   task automatic sel(input logic [6:0] idx);
      @(posedge clock_in);
      index_wr_out <= 1'b1;
      wdata_out <= {1'b0, idx};
      @(posedge clock_in);
      index_wr_out <= 1'b0;
   endtask
   // Released data lines are inverted so a stale byte cannot pass for a live one.
   task automatic wr(input logic [6:0] idx, input logic [7:0] val);
      sel(idx);
      data_wr_out <= 1'b1;
      wdata_out <= val;
      @(posedge clock_in);
      data_wr_out <= 1'b0;
      wdata_out <= ~val;
   endtask
   task automatic rd(input logic [6:0] idx, output logic [7:0] val);
      sel(idx);
      data_rd_out <= 1'b1;
      wdata_out <= ~wdata_out;
      @(posedge clock_in);
      data_rd_out <= 1'b0;
      #1;
      val = rdata_in;
   endtask
endmodule // rtcc_host

// *** rtcc_ctrl_status_bench.sv ***
// Self-checking bench for the clock control block.
module rtcc_ctrl_status_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clock_in = 1'b0;
   logic       rst_n_in = 1'b0;
   logic       osc_32k_in = 1'b0;
   logic       power_ok_in = 1'b1;
   logic       alarm_match_in = 1'b0;
   logic       index_wr;
   logic       data_wr;
   logic       data_rd;
   logic [7:0] wdata;
   logic [7:0] rdata_out;
   logic       irq_out;
   logic       update_tick_out;
   wire  [2:0] fmt;
   int         num_errors = 0;
   int         n_tests = 0;
   always #5 clock_in = ~clock_in;
   rtcc_host i_rtcc_host (.clock_in(clock_in), .rdata_in(rdata_out), .index_wr_out(index_wr),
      .data_wr_out(data_wr), .data_rd_out(data_rd), .wdata_out(wdata));
   rtcc_ctrl_status i_rtcc_ctrl_status (.clock_in(clock_in), .rst_n_in(rst_n_in),
      .index_wr_in(index_wr), .data_wr_in(data_wr), .data_rd_in(data_rd), .wdata_in(wdata),
      .osc_32k_in(osc_32k_in), .power_ok_in(power_ok_in), .alarm_match_in(alarm_match_in),
      .rdata_out(rdata_out), .irq_out(irq_out), .update_tick_out(update_tick_out),
      .binary_fmt_out(fmt[2]), .hour24_out(fmt[1]), .dst_en_out(fmt[0]));
   // ------------------------------
   // Helpers and scenarios
   // ------------------------------
   task automatic end_sim();
      if (num_errors == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [6:0] idx, input logic [7:0] exp);
      logic [7:0] v;
      i_rtcc_host.rd(idx, v);
      chk({8'h00, v}, {8'h00, exp});
   endtask
   task automatic do_reset();
      @(posedge clock_in);
      rst_n_in <= 1'b0;
      repeat (16) @(posedge clock_in);
      rst_n_in <= 1'b1;
   endtask
   // The pin stays high for four clocks and low for at least four to clear the synchroniser.
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clock_in);
         osc_32k_in <= 1'b1;
         repeat (4) @(posedge clock_in);
         osc_32k_in <= 1'b0;
         repeat (4) @(posedge clock_in);
      end
   endtask
   task automatic ticks_to_irq(input int lim, output int cnt);
      cnt = 0;
      #1;
      while (irq_out !== 1'b1) begin
         if (cnt == lim) begin
            num_errors++;
            end_sim();
         end
         tick(1);
         #1;
         cnt++;
      end
   endtask
   task automatic t_reset();
      logic [6:0] idx [6] = '{7'h0A, 7'h0B, 7'h0C, 7'h0D, 7'h0E, 7'h05};
      logic [7:0] exp [6] = '{8'h20, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00};
      foreach (idx[k]) rd_chk(idx[k], exp[k]);
   endtask
   task automatic t_mode();
      logic [7:0] m [3] = '{8'hFF, 8'h05, 8'h02};
      foreach (m[k]) begin
         i_rtcc_host.wr(7'h0B, m[k]);
         rd_chk(7'h0B, m[k] & 8'hF7);
         chk({13'h0, fmt}, {13'h0, m[k][2:0]});
      end
      i_rtcc_host.wr(7'h0C, 8'hFF);
      rd_chk(7'h0C, 8'h00);
      i_rtcc_host.wr(7'h0A, 8'hFF);
      rd_chk(7'h0A, 8'h7F);
      i_rtcc_host.wr(7'h0A, 8'h20);
   endtask
   task automatic t_alarm();
      logic [7:0] en [2] = '{8'h20, 8'h00};
      foreach (en[k]) begin
         i_rtcc_host.wr(7'h0B, en[k]);
         @(posedge clock_in);
         alarm_match_in <= 1'b1;
         @(posedge clock_in);
         alarm_match_in <= 1'b0;
         #1;
         chk({15'h0, irq_out}, {15'h0, en[k][5]});
         rd_chk(7'h0C, {en[k][5], 7'h20});
         chk({15'h0, irq_out}, 16'h0);
      end
   endtask
   task automatic t_periodic();
      logic [3:0] code [5] = '{4'h1, 4'h2, 4'h3, 4'h8, 4'h9};
      int         span [5] = '{128, 256, 4, 128, 256};
      int         n;
      i_rtcc_host.wr(7'h0B, 8'h40);
      foreach (code[k]) begin
         i_rtcc_host.wr(7'h0A, {4'h2, code[k]});
         ticks_to_irq(300, n);
         rd_chk(7'h0C, 8'hC0);
         ticks_to_irq(300, n);
         chk(n[15:0], span[k][15:0]);
         rd_chk(7'h0C, 8'hC0);
      end
   endtask
   task automatic t_div();
      logic [7:0] r [3] = '{8'h03, 8'h63, 8'h20};
      logic [7:0] v;
      foreach (r[k]) begin
         i_rtcc_host.wr(7'h0A, r[k]);
         rd_chk(7'h0A, r[k]);
         i_rtcc_host.rd(7'h0C, v);
         tick(32);
         #1;
         chk({15'h0, irq_out}, 16'h0);
      end
      i_rtcc_host.wr(7'h0A, 8'h23);
      i_rtcc_host.wr(7'h0B, 8'h00);
      tick(8);
      #1;
      chk({15'h0, irq_out}, 16'h0);
      chk({15'h0, update_tick_out}, 16'h0);
      rd_chk(7'h0C, 8'h40);
   endtask
   task automatic t_power();
      logic [7:0] v;
      i_rtcc_host.wr(7'h0D, 8'h00);
      rd_chk(7'h0D, 8'h80);
      @(posedge clock_in);
      power_ok_in <= 1'b0;
      repeat (4) @(posedge clock_in);
      rd_chk(7'h0D, 8'h00);
      @(posedge clock_in);
      power_ok_in <= 1'b1;
      repeat (4) @(posedge clock_in);
      i_rtcc_host.rd(7'h0D, v);
      rd_chk(7'h0D, 8'h80);
   endtask
   initial begin
      do_reset();
      t_reset();
      t_mode();
      t_alarm();
      t_periodic();
      t_div();
      t_power();
      do_reset();
      t_reset();
      end_sim();
   end
endmodule // rtcc_ctrl_status_bench
